// ===== hw/fdd_density_pkg.sv
// Package holding constants and types for the floppy density select block
package fdd_density_pkg;

  localparam int        NUM_DRIVES        = 4;
  // Option register field positions
  localparam int        OPT_PRECOMP_SKIP  = 6;
  localparam int        OPT_RATE_TABLE_HI = 4;
  localparam int        OPT_RATE_TABLE_LO = 3;
  localparam int        OPT_DRIVE_TYPE_B0 = 1;
  localparam int        OPT_DRIVE_TYPE_B1 = 0;
  localparam logic [7:0] OPT_WRITE_MASK   = 8'h5B;
  localparam logic [7:0] OPT_RESET        = 8'h00;
  // Digital output register DMA gate bit and rate select reset value
  localparam int        DOR_DMA_GATE      = 3;
  localparam logic [1:0] RATE_SEL_RESET   = 2'h2;
  // Register selects on the control port
  localparam logic [1:0] SEL_RATE_DATA    = 2'h0;
  localparam logic [1:0] SEL_RATE_CFG     = 2'h1;
  localparam logic [1:0] SEL_DOR          = 2'h2;

  typedef enum logic [1:0] {
    RATE_500K  = 2'b00,
    RATE_300K  = 2'b01,
    RATE_250K  = 2'b10,
    RATE_1M    = 2'b11
  } rate_sel_e;

  typedef enum logic [1:0] {
    TABLE_REGULAR = 2'b00,
    TABLE_500K_ALT = 2'b01,
    TABLE_2M      = 2'b10,
    TABLE_RSVD    = 2'b11
  } rate_table_e;

  typedef enum logic [2:0] {
    KBPS_250  = 3'b000,
    KBPS_300  = 3'b001,
    KBPS_500  = 3'b010,
    KBPS_1000 = 3'b011,
    KBPS_2000 = 3'b100
  } mfm_rate_e;

  // Decoded option register
  typedef struct packed {
    logic        precomp_skip;
    rate_table_e rate_table;
    logic [1:0]  drive_type;
  } drive_opt_s;

  // Result of the rate table lookup
  typedef struct packed {
    logic      density;
    logic      rate_code_b1;
    logic      rate_code_b0;
    mfm_rate_e mfm_rate;
  } rate_map_s;

endpackage

// ===== hw/fdd_rate_map.sv
// Combinational rate table lookup for one drive
`timescale 1ns/100ps
module fdd_rate_map
  import fdd_density_pkg::*;
(
  input  wire rate_table_e rate_table,
  input  wire logic [1:0]  rate_sel,
  output rate_map_s        map
);

  always_comb
  begin
    map.rate_code_b1 = rate_sel[1];
    map.rate_code_b0 = rate_sel[0];
    case (rate_sel)
      2'b00:
      begin
        map.density  = 1'b1;
        map.mfm_rate = KBPS_500;
      end
      2'b01:
      begin
        map.density = 1'b0;
        case (rate_table)
          TABLE_500K_ALT: map.mfm_rate = KBPS_500;
          TABLE_2M:       map.mfm_rate = KBPS_2000;
          default:        map.mfm_rate = KBPS_300;
        endcase
      end
      2'b10:
      begin
        map.density  = 1'b0;
        map.mfm_rate = KBPS_250;
      end
      default:
      begin
        map.density  = 1'b1;
        map.mfm_rate = KBPS_1000;
      end
    endcase
  end

endmodule

// ===== hw/floppy_density_select.sv
// Per-drive option registers and density pin mapping of the floppy core
`timescale 1ns/100ps
module floppy_density_select
  import fdd_density_pkg::*;
#(
  parameter int DRIVES = NUM_DRIVES
)
(
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  input  wire logic                      opt_wr,
  input  wire logic [1:0]                opt_idx,
  input  wire logic [7:0]                opt_wdata,
  output logic [7:0]                     opt_rdata,
  input  wire logic                      ctl_wr,
  input  wire logic [1:0]                ctl_sel,
  input  wire logic [7:0]                ctl_wdata,
  input  wire logic                      burst_sel,
  input  wire logic [$clog2(DRIVES)-1:0] drive_sel,
  input  wire logic                      core_enable,
  input  wire logic                      core_power_down,
  input  wire logic                      core_irq,
  input  wire logic                      core_dma_ack,
  output logic                           drive_density_pin_a,
  output logic                           drive_density_pin_b,
  output logic                           precomp_enable,
  output logic                           dma_burst,
  output logic [2:0]                     mfm_rate,
  output logic [1:0]                     rate_sel_out,
  output logic                           irq_out,
  output logic                           irq_oe,
  output logic                           dma_acknowledge_out,
  output logic                           dma_acknowledge_oe
);

  logic [7:0]       opt_reg [DRIVES];
  logic [1:0]       rate_sel_reg;
  logic             dma_gate_bit_reg;
  logic             burst_reg;
  drive_opt_s       cur_opt;
  rate_map_s        cur_map;
  logic             pin_a_next;
  logic             pin_b_next;

  // One option register per drive, unused bits never stored
  genvar gi;
  generate
    for (gi = 0; gi < DRIVES; gi++)
    begin : g_opt
      always_ff @(posedge clk_sys)
      begin
        if (!rstn)
          opt_reg[gi] <= OPT_RESET;
        else if (opt_wr && opt_idx == 2'(gi))
          opt_reg[gi] <= opt_wdata & OPT_WRITE_MASK;
      end
    end
  endgenerate

  assign opt_rdata = opt_reg[opt_idx];

  // Both rate registers feed the same two select bits
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      rate_sel_reg <= RATE_SEL_RESET;
    else if (ctl_wr && (ctl_sel == SEL_RATE_DATA || ctl_sel == SEL_RATE_CFG))
      rate_sel_reg <= ctl_wdata[1:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      dma_gate_bit_reg <= 1'b0;
    else if (ctl_wr && ctl_sel == SEL_DOR)
      dma_gate_bit_reg <= ctl_wdata[DOR_DMA_GATE];
  end

  // Non-burst out of reset; software opts in
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      burst_reg <= 1'b0;
    else
      burst_reg <= burst_sel;
  end
  assign dma_burst = burst_reg;

  always_comb
  begin
    cur_opt.precomp_skip = opt_reg[drive_sel][OPT_PRECOMP_SKIP];
    cur_opt.rate_table   = rate_table_e'({opt_reg[drive_sel][OPT_RATE_TABLE_HI],
                                          opt_reg[drive_sel][OPT_RATE_TABLE_LO]});
    cur_opt.drive_type   = {opt_reg[drive_sel][OPT_DRIVE_TYPE_B1],
                            opt_reg[drive_sel][OPT_DRIVE_TYPE_B0]};
  end

  fdd_rate_map u_map (
    .rate_table (cur_opt.rate_table),
    .rate_sel   (rate_sel_reg),
    .map        (cur_map)
  );

  // drive_type is {bit1 (reg bit0), bit0 (reg bit1)}; table lists {b0,b1}
  always_comb
  begin
    case ({cur_opt.drive_type[0], cur_opt.drive_type[1]})
      2'b00:
      begin
        pin_a_next = cur_map.density;
        pin_b_next = cur_map.rate_code_b0;
      end
      2'b01:
      begin
        pin_a_next = cur_map.rate_code_b1;
        pin_b_next = cur_map.rate_code_b0;
      end
      2'b10:
      begin
        pin_a_next = ~cur_map.density;
        pin_b_next = cur_map.rate_code_b0;
      end
      default:
      begin
        pin_a_next = cur_map.rate_code_b0;
        pin_b_next = cur_map.rate_code_b1;
      end
    endcase
  end

  // Registered so the pins never glitch while drive select settles
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      drive_density_pin_a <= 1'b0;
      drive_density_pin_b <= 1'b0;
      precomp_enable      <= 1'b0;
      mfm_rate            <= 3'h0;
      rate_sel_out        <= 2'h0;
    end
    else
    begin
      drive_density_pin_a <= pin_a_next;
      drive_density_pin_b <= pin_b_next;
      precomp_enable      <= ~cur_opt.precomp_skip;
      mfm_rate            <= cur_map.mfm_rate;
      rate_sel_out        <= rate_sel_reg;
    end
  end

  // Output enables: floated unless gated on and core alive
  logic outs_live;
  assign outs_live          = dma_gate_bit_reg && core_enable && !core_power_down;
  assign irq_out            = core_irq;
  assign irq_oe             = outs_live;
  assign dma_acknowledge_out = core_dma_ack;
  assign dma_acknowledge_oe = outs_live;

  // Checks; density is high exactly when both select bits agree
  pins_follow_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (opt_reg[drive_sel][1:0] != 2'b11) |=> drive_density_pin_b == $past(rate_sel_reg[0]))
    else $error("density pin b not following rate bit 0");
  type00_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (opt_reg[drive_sel][1:0] == 2'b00) |=> drive_density_pin_a == $past(rate_sel_reg[1] == rate_sel_reg[0]))
    else $error("type 00 pin a not density");
  type01_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (opt_reg[drive_sel][1:0] == 2'b01) |=> drive_density_pin_a == $past(rate_sel_reg[1]))
    else $error("type 01 pin a not rate bit 1");
  type10_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (opt_reg[drive_sel][1:0] == 2'b10) |=> drive_density_pin_a == $past(rate_sel_reg[1] != rate_sel_reg[0]))
    else $error("type 10 pin a not inverted density");
  type11_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (opt_reg[drive_sel][1:0] == 2'b11) |=> drive_density_pin_b == $past(rate_sel_reg[1]))
    else $error("type 11 pin b not rate bit 1");
  precomp_en_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> precomp_enable == !$past(opt_reg[drive_sel][OPT_PRECOMP_SKIP]))
    else $error("precompensation enable wrong");
  rate_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctl_wr && ctl_sel == SEL_RATE_CFG) |=> rate_sel_reg == $past(ctl_wdata[1:0]))
    else $error("config control write lost rate select");
  rate_data_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ctl_wr && ctl_sel == SEL_RATE_DATA) |=> rate_sel_reg == $past(ctl_wdata[1:0]))
    else $error("data rate write lost rate select");
  gate_float_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !dma_gate_bit_reg |-> !irq_oe && !dma_acknowledge_oe)
    else $error("outputs driven with gate off");
  power_float_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (core_power_down || !core_enable) |-> !irq_oe && !dma_acknowledge_oe)
    else $error("outputs driven while powered down");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (opt_rdata & ~OPT_WRITE_MASK) == 8'h00)
    else $error("reserved option bits nonzero");
  mask_store_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (opt_wr ##1 $stable(opt_idx)) |-> opt_rdata == ($past(opt_wdata) & OPT_WRITE_MASK))
    else $error("option write not stored masked");
  burst_reset_a: assert property (@(posedge clk_sys)
    !rstn |=> !dma_burst)
    else $error("burst after reset");
  table2m_rate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cur_opt.rate_table == TABLE_2M && rate_sel_reg == 2'b01) |=> mfm_rate == KBPS_2000)
    else $error("2 Mbit rate not chosen");
  table01_rate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cur_opt.rate_table == TABLE_500K_ALT && rate_sel_reg == 2'b01) |=> mfm_rate == KBPS_500)
    else $error("alt table rate wrong");
  table00_rate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cur_opt.rate_table == TABLE_REGULAR && rate_sel_reg == 2'b01) |=> mfm_rate == KBPS_300)
    else $error("regular table rate wrong");

endmodule

// ===== testbench/fdd_drive_model.sv
// Behavioural floppy drive that latches the two density lines
`timescale 1ns/100ps
module fdd_drive_model
(
  input  wire logic       clk_sys,
  input  wire logic       drive_density_pin_a,
  input  wire logic       drive_density_pin_b,
  output logic [1:0]      seen_pins
);
  // A real drive only sees the lines, so the rate and type tests judge them through here
  always_ff @(posedge clk_sys)
  begin
    seen_pins <= {drive_density_pin_a, drive_density_pin_b};
  end
endmodule

// ===== testbench/tb_floppy_density_select.sv
// Self-checking bench for the floppy density select block
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %0h want %0h", $time, (a), (b)); end end
module tb_floppy_density_select;
  import fdd_density_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic       opt_wr = 1'b0;
  logic [1:0] opt_idx = 2'h0;
  logic [7:0] opt_wdata = 8'h00;
  logic       ctl_wr = 1'b0;
  logic [1:0] ctl_sel = 2'h0;
  logic [7:0] ctl_wdata = 8'h00;
  logic       burst_sel = 1'b0;
  logic [1:0] drive_sel = 2'h0;
  logic       core_enable = 1'b0;
  logic       core_power_down = 1'b0;
  logic       core_irq = 1'b0;
  logic       core_dma_ack = 1'b0;
  logic [7:0] opt_rdata;
  logic       pin_a, pin_b, precomp_enable, dma_burst;
  logic [2:0] mfm_rate;
  logic [1:0] rate_sel_out, seen_pins;
  logic       irq_out, irq_oe, dma_acknowledge_out, dma_acknowledge_oe;
  int         fail_count = 0;
  int         num_checks = 0;

  floppy_density_select dut (.clk_sys(clk_sys), .rstn(rstn), .opt_wr(opt_wr), .opt_idx(opt_idx),
    .opt_wdata(opt_wdata), .opt_rdata(opt_rdata), .ctl_wr(ctl_wr), .ctl_sel(ctl_sel),
    .ctl_wdata(ctl_wdata), .burst_sel(burst_sel), .drive_sel(drive_sel), .core_enable(core_enable),
    .core_power_down(core_power_down), .core_irq(core_irq), .core_dma_ack(core_dma_ack),
    .drive_density_pin_a(pin_a), .drive_density_pin_b(pin_b), .precomp_enable(precomp_enable),
    .dma_burst(dma_burst), .mfm_rate(mfm_rate), .rate_sel_out(rate_sel_out), .irq_out(irq_out),
    .irq_oe(irq_oe), .dma_acknowledge_out(dma_acknowledge_out), .dma_acknowledge_oe(dma_acknowledge_oe));
  fdd_drive_model drive (.clk_sys(clk_sys), .drive_density_pin_a(pin_a),
    .drive_density_pin_b(pin_b), .seen_pins(seen_pins));

  always #5 clk_sys = ~clk_sys;

  function automatic logic [1:0] exp_pins(input logic [1:0] s, input logic [1:0] y);
    logic dens;
    dens = (s == 2'h0) || (s == 2'h3);
    case (y)
      2'h0: exp_pins = {dens, s[0]};
      2'h1: exp_pins = {s[1], s[0]};
      2'h2: exp_pins = {~dens, s[0]};
      default: exp_pins = {s[0], s[1]};
    endcase
  endfunction

  function automatic logic [2:0] exp_rate(input logic [1:0] t, input logic [1:0] s);
    case (s)
      2'h0: exp_rate = 3'h2;
      2'h1: exp_rate = (t == 2'h1) ? 3'h2 : ((t == 2'h2) ? 3'h4 : 3'h1);
      2'h2: exp_rate = 3'h0;
      default: exp_rate = 3'h3;
    endcase
  endfunction

  task automatic wr_opt(input logic [1:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    opt_wr <= 1'b1;
    opt_idx <= idx;
    opt_wdata <= d;
    @(posedge clk_sys);
    opt_wr <= 1'b0;
  endtask

  task automatic wr_ctl(input logic [1:0] sel, input logic [7:0] d);
    @(posedge clk_sys);
    ctl_wr <= 1'b1;
    ctl_sel <= sel;
    ctl_wdata <= d;
    @(posedge clk_sys);
    ctl_wr <= 1'b0;
  endtask

  // Two edges: one for the pins, one for the drive to latch them
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_reset();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      opt_idx <= 2'(i);
      #1;
      `CHK(opt_rdata, 8'h00)
    end
    `CHK(rate_sel_out, 2'h2)
    `CHK(dma_burst, 1'b0)
    `CHK(irq_oe, 1'b0)
    @(posedge clk_sys);
    burst_sel <= 1'b1;
    settle();
    `CHK(dma_burst, 1'b1)
  endtask

  task automatic t_mask();
    wr_opt(2'h1, 8'hFF);
    #1;
    `CHK(opt_rdata, 8'h5B)
    wr_opt(2'h1, 8'h00);
  endtask

  task automatic t_rates();
    for (int t = 0; t < 3; t++)
      for (int s = 0; s < 4; s++)
      begin
        wr_opt(2'h0, 8'(t << 3));
        // Alternate between data-rate and config control writes
        wr_ctl(2'(s & 1), 8'(s));
        settle();
        `CHK(seen_pins, exp_pins(2'(s), 2'h0))
        `CHK(mfm_rate, exp_rate(2'(t), 2'(s)))
        `CHK(rate_sel_out, 2'(s))
      end
  endtask

  task automatic t_types();
    @(posedge clk_sys);
    drive_sel <= 2'h2;
    for (int y = 0; y < 4; y++)
      for (int s = 0; s < 4; s++)
      begin
        wr_opt(2'h2, 8'(y));
        wr_ctl(2'h0, 8'(s));
        wr_ctl(2'h3, 8'(~s));
        settle();
        `CHK(seen_pins, exp_pins(2'(s), 2'(y)))
        `CHK(rate_sel_out, 2'(s))
      end
  endtask

  task automatic t_follow();
    wr_opt(2'h3, 8'h40);
    wr_opt(2'h0, 8'h01);
    wr_opt(2'h1, 8'h03);
    wr_ctl(2'h1, 8'h01);
    @(posedge clk_sys);
    drive_sel <= 2'h3;
    settle();
    `CHK(precomp_enable, 1'b0)
    @(posedge clk_sys);
    drive_sel <= 2'h0;
    @(posedge clk_sys);
    #1;
    `CHK({pin_a, pin_b}, exp_pins(2'h1, 2'h1))
    `CHK(precomp_enable, 1'b1)
    @(posedge clk_sys);
    drive_sel <= 2'h1;
    @(posedge clk_sys);
    #1;
    `CHK({pin_a, pin_b}, exp_pins(2'h1, 2'h3))
  endtask

  task automatic t_gate();
    @(posedge clk_sys);
    core_enable <= 1'b1;
    core_irq <= 1'b1;
    core_dma_ack <= 1'b0;
    wr_ctl(2'h2, 8'h08);
    settle();
    `CHK({irq_oe, dma_acknowledge_oe}, 2'h3)
    `CHK({irq_out, dma_acknowledge_out}, 2'h2)
    @(posedge clk_sys);
    core_power_down <= 1'b1;
    #1;
    `CHK({irq_oe, dma_acknowledge_oe}, 2'h0)
    @(posedge clk_sys);
    core_power_down <= 1'b0;
    core_enable <= 1'b0;
    #1;
    `CHK({irq_oe, dma_acknowledge_oe}, 2'h0)
    @(posedge clk_sys);
    core_enable <= 1'b1;
    wr_ctl(2'h2, 8'hF7);
    settle();
    `CHK({irq_oe, dma_acknowledge_oe}, 2'h0)
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #200000;
    fail_count++;
    wrap_up();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_mask();
    t_rates();
    t_types();
    t_follow();
    t_gate();
    wrap_up();
  end
endmodule
